// ---- rtl/ttws_defs.vh ----
`ifndef TTWS_DEFS_VH
`define TTWS_DEFS_VH

// ----------------------------------------------------------------
// Bus addresses
// ----------------------------------------------------------------
`define TTWS_ADDR_A 7'h44
`define TTWS_ADDR_B 7'h46
`define TTWS_SUB_EV_FIRST 8'h78
`define TTWS_SUB_EV_LAST 8'h79
`define TTWS_SUB_FIRST_ACT 8'h7a
`define TTWS_SUB_LAST_ACT 8'h7b
`define TTWS_SUB_HIGH_STD 8'h7c
`define TTWS_SUB_MASK_LO 8'h7e
`define TTWS_SUB_MASK_HI 8'h7f
`define TTWS_SUB_CC_ODD_1 8'h67
`define TTWS_SUB_CC_ODD_2 8'h68
`define TTWS_SUB_CC_EVEN_1 8'h69
`define TTWS_SUB_CC_EVEN_2 8'h6a

// ----------------------------------------------------------------
// Field positions in the high-bits and standard register
// ----------------------------------------------------------------
`define TTWS_HB_EV_FIRST 0
`define TTWS_HB_EV_LAST 1
`define TTWS_HB_FIRST_ACT 2
`define TTWS_HB_LAST_ACT 3
`define TTWS_HB_STD 7

// ----------------------------------------------------------------
// Reset values and line offsets
// ----------------------------------------------------------------
`define TTWS_RST_BYTE 8'h00
`define TTWS_RST_MASK 16'h0000
// Version code: value is arbitrary
`define TTWS_VERSION 3'h5
`define TTWS_FIRST_OFS_M 10'h004
`define TTWS_FIRST_OFS_O 10'h001
`define TTWS_LAST_OFS_M 10'h003
`define TTWS_LAST_OFS_O 10'h000
`define TTWS_MASK_BASE 10'h005
`define TTWS_MASK_SPAN 10'h010

// ----------------------------------------------------------------
// Text modes on the output
// ----------------------------------------------------------------
`define TTWS_MODE_EURO 2'h0
`define TTWS_MODE_NABTS 2'h1
`define TTWS_MODE_WST 2'h2

`endif

// ---- rtl/ttws_window_status.v ----
`include "ttws_defs.vh"

module ttws_window_status (
  input wire i_clk,
  input wire i_reset,
  input wire i_scl,
  input wire i_sda_in,
  output wire o_sda_out,
  output wire o_sda_oe,
  input wire i_field_start,
  input wire [9:0] i_line_num,
  input wire i_field_rate_select,
  input wire i_text_insert_enable,
  input wire [8:0] i_odd_text_first_line,
  input wire [8:0] i_odd_text_last_line,
  input wire i_caption_odd_done,
  input wire i_caption_even_done,
  output wire o_text_request_out,
  output wire o_active_line,
  output wire [1:0] o_text_mode,
  output wire o_field_even,
  output wire [2:0] o_field_seq
);

  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_ADDR = 6'h02;
  localparam [5:0] S_ACK = 6'h04;
  localparam [5:0] S_RX = 6'h08;
  localparam [5:0] S_TX = 6'h10;
  localparam [5:0] S_TXACK = 6'h20;

  // ----------------------------------------------------------------
  // Bus pin edges
  // ----------------------------------------------------------------
  reg scl_q, sda_q;
  wire scl_rise = i_scl & ~scl_q;
  wire scl_fall = ~i_scl & scl_q;
  wire bus_start = scl_q & i_scl & sda_q & ~i_sda_in;
  wire bus_stop = scl_q & i_scl & ~sda_q & i_sda_in;

  reg [5:0] state_q;
  reg [3:0] bit_cnt_q;
  reg [7:0] shift_q, sub_q, wr_sub, wr_data;
  reg is_sub_q, read_q, nack_q, sda_oe_q, sda_out_q, wr_stb;

  // Host-written settings and their field-aligned copies
  reg [7:0] ev_first_q, ev_last_q, first_act_q, last_act_q, high_std_q;
  reg [7:0] ev_first_s, ev_last_s, first_act_s, last_act_s, high_std_s;
  reg [15:0] mask_q, mask_s;

  reg cc_odd_q, cc_even_q;
  reg [1:0] cc_odd_wr_q, cc_even_wr_q;
  reg [2:0] field_sequence_count_q, field_sequence_count_d;

  reg text_req_q, active_q;
  reg [1:0] mode_q;

  wire [7:0] status = {`TTWS_VERSION, cc_odd_q, cc_even_q, field_sequence_count_q};
  wire addr_hit = (shift_q[7:1] == `TTWS_ADDR_A) || (shift_q[7:1] == `TTWS_ADDR_B);

  // ----------------------------------------------------------------
  // Bus slave: address, subaddress, auto-increment writes, status reads
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    wr_stb <= 1'b0;
    if (i_reset) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      state_q <= S_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      sub_q <= 8'h00;
      is_sub_q <= 1'b0;
      read_q <= 1'b0;
      nack_q <= 1'b0;
      sda_oe_q <= 1'b0;
      sda_out_q <= 1'b0;
      wr_sub <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda_in;
      if (bus_stop) begin
        state_q <= S_IDLE;
        sda_oe_q <= 1'b0;
      end else if (bus_start) begin
        state_q <= S_ADDR;
        bit_cnt_q <= 4'h0;
        sda_oe_q <= 1'b0;
      end else begin
        case (state_q)
          S_ADDR, S_RX: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], i_sda_in};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall && bit_cnt_q == 4'h8) begin
              if (state_q == S_ADDR) begin
                if (addr_hit) begin
                  read_q <= shift_q[0];
                  is_sub_q <= 1'b1;
                  state_q <= S_ACK;
                  sda_oe_q <= 1'b1;
                end else begin
                  state_q <= S_IDLE;
                end
              end else begin
                if (is_sub_q) begin
                  sub_q <= shift_q;
                  is_sub_q <= 1'b0;
                end else begin
                  wr_stb <= 1'b1;
                  wr_sub <= sub_q;
                  wr_data <= shift_q;
                  sub_q <= sub_q + 8'h01;
                end
                state_q <= S_ACK;
                sda_oe_q <= 1'b1;
              end
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              bit_cnt_q <= 4'h0;
              if (read_q) begin
                state_q <= S_TX;
                shift_q <= status;
                sda_oe_q <= ~status[7];
              end else begin
                state_q <= S_RX;
                sda_oe_q <= 1'b0;
              end
            end
          end
          S_TX: begin
            if (scl_rise) begin
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt_q == 4'h8) begin
                state_q <= S_TXACK;
                sda_oe_q <= 1'b0;
              end else begin
                shift_q <= {shift_q[6:0], 1'b0};
                sda_oe_q <= ~shift_q[6];
              end
            end
          end
          S_TXACK: begin
            if (scl_rise) begin
              nack_q <= i_sda_in;
            end else if (scl_fall) begin
              bit_cnt_q <= 4'h0;
              if (nack_q) begin
                state_q <= S_IDLE;
              end else begin
                state_q <= S_TX;
                shift_q <= status;
                sda_oe_q <= ~status[7];
              end
            end
          end
          default: begin
            state_q <= S_IDLE;
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Setting registers and field-boundary copies
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_reset) begin
      ev_first_q <= `TTWS_RST_BYTE;
      ev_last_q <= `TTWS_RST_BYTE;
      first_act_q <= `TTWS_RST_BYTE;
      last_act_q <= `TTWS_RST_BYTE;
      high_std_q <= `TTWS_RST_BYTE;
      mask_q <= `TTWS_RST_MASK;
      ev_first_s <= `TTWS_RST_BYTE;
      ev_last_s <= `TTWS_RST_BYTE;
      first_act_s <= `TTWS_RST_BYTE;
      last_act_s <= `TTWS_RST_BYTE;
      high_std_s <= `TTWS_RST_BYTE;
      mask_s <= `TTWS_RST_MASK;
    end else begin
      if (wr_stb) begin
        if (wr_sub == `TTWS_SUB_EV_FIRST) begin
          ev_first_q <= wr_data;
        end else if (wr_sub == `TTWS_SUB_EV_LAST) begin
          ev_last_q <= wr_data;
        end else if (wr_sub == `TTWS_SUB_FIRST_ACT) begin
          first_act_q <= wr_data;
        end else if (wr_sub == `TTWS_SUB_LAST_ACT) begin
          last_act_q <= wr_data;
        end else if (wr_sub == `TTWS_SUB_HIGH_STD) begin
          high_std_q <= wr_data;
        end else if (wr_sub == `TTWS_SUB_MASK_LO) begin
          mask_q[7:0] <= wr_data;
        end else if (wr_sub == `TTWS_SUB_MASK_HI) begin
          mask_q[15:8] <= wr_data;
        end
      end
      if (i_field_start) begin
        ev_first_s <= ev_first_q;
        ev_last_s <= ev_last_q;
        first_act_s <= first_act_q;
        last_act_s <= last_act_q;
        high_std_s <= high_std_q;
        mask_s <= mask_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Caption done flags; an encode event wins over a clear
  // ----------------------------------------------------------------
  wire wr_cc_o1 = wr_stb && (wr_sub == `TTWS_SUB_CC_ODD_1);
  wire wr_cc_o2 = wr_stb && (wr_sub == `TTWS_SUB_CC_ODD_2);
  wire wr_cc_e1 = wr_stb && (wr_sub == `TTWS_SUB_CC_EVEN_1);
  wire wr_cc_e2 = wr_stb && (wr_sub == `TTWS_SUB_CC_EVEN_2);
  wire [1:0] cc_odd_seen = cc_odd_wr_q | {wr_cc_o2, wr_cc_o1};
  wire [1:0] cc_even_seen = cc_even_wr_q | {wr_cc_e2, wr_cc_e1};

  always @(posedge i_clk) begin
    if (i_reset) begin
      cc_odd_q <= 1'b0;
      cc_even_q <= 1'b0;
      cc_odd_wr_q <= 2'h0;
      cc_even_wr_q <= 2'h0;
    end else begin
      cc_odd_wr_q <= (cc_odd_seen == 2'h3) ? 2'h0 : cc_odd_seen;
      cc_even_wr_q <= (cc_even_seen == 2'h3) ? 2'h0 : cc_even_seen;
      if (i_caption_odd_done) begin
        cc_odd_q <= 1'b1;
      end else if (cc_odd_seen == 2'h3) begin
        cc_odd_q <= 1'b0;
      end
      if (i_caption_even_done) begin
        cc_even_q <= 1'b1;
      end else if (cc_even_seen == 2'h3) begin
        cc_even_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Field sequence counter
  // ----------------------------------------------------------------
  always @* begin
    field_sequence_count_d = field_sequence_count_q + 3'h1;
    if (i_field_rate_select) begin
      field_sequence_count_d = {1'b0, field_sequence_count_q[1:0] + 2'h1};
    end
  end

  always @(posedge i_clk) begin
    if (i_reset) begin
      field_sequence_count_q <= 3'h0;
    end else if (i_field_start) begin
      field_sequence_count_q <= field_sequence_count_d;
    end
  end

  // ----------------------------------------------------------------
  // Line windows, mask and text mode
  // ----------------------------------------------------------------
  wire m_sys = i_field_rate_select;
  wire [9:0] ev_first_v = {1'b0, high_std_s[`TTWS_HB_EV_FIRST], ev_first_s};
  wire [9:0] ev_last_v = {1'b0, high_std_s[`TTWS_HB_EV_LAST], ev_last_s};
  wire [9:0] fa_v = {1'b0, high_std_s[`TTWS_HB_FIRST_ACT], first_act_s};
  wire [9:0] la_v = {1'b0, high_std_s[`TTWS_HB_LAST_ACT], last_act_s};
  wire [9:0] first_ofs = m_sys ? `TTWS_FIRST_OFS_M : `TTWS_FIRST_OFS_O;
  wire [9:0] last_ofs = m_sys ? `TTWS_LAST_OFS_M : `TTWS_LAST_OFS_O;
  wire [9:0] ev_start = ev_first_v + first_ofs;
  wire [9:0] ev_end = ev_last_v + last_ofs;
  wire [9:0] od_start = {1'b0, i_odd_text_first_line} + first_ofs;
  wire [9:0] od_end = {1'b0, i_odd_text_last_line} + last_ofs;
  wire [9:0] act_start = fa_v + first_ofs;
  wire [9:0] act_end = la_v + last_ofs;
  wire field_even = field_sequence_count_q[0];
  wire in_even = field_even && (i_line_num >= ev_start) && (i_line_num <= ev_end);
  wire in_odd = ~field_even && (i_line_num >= od_start) && (i_line_num <= od_end);
  wire [9:0] mask_off = i_line_num - `TTWS_MASK_BASE;
  wire mask_hit = (i_line_num >= `TTWS_MASK_BASE) && (mask_off < `TTWS_MASK_SPAN) &&
                  mask_s[mask_off[3:0]];
  wire std_sel = high_std_s[`TTWS_HB_STD];

  always @(posedge i_clk) begin
    if (i_reset) begin
      text_req_q <= 1'b0;
      active_q <= 1'b0;
      mode_q <= `TTWS_MODE_EURO;
    end else begin
      text_req_q <= i_text_insert_enable && (in_even || in_odd) && ~mask_hit;
      active_q <= (i_line_num >= act_start) && (i_line_num <= act_end);
      if (~m_sys) begin
        mode_q <= `TTWS_MODE_EURO;
      end else if (std_sel) begin
        mode_q <= `TTWS_MODE_WST;
      end else begin
        mode_q <= `TTWS_MODE_NABTS;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_sda_out = sda_out_q;
  assign o_sda_oe = sda_oe_q;
  assign o_text_request_out = text_req_q;
  assign o_active_line = active_q;
  assign o_text_mode = mode_q;
  assign o_field_even = field_sequence_count_q[0];
  assign o_field_seq = field_sequence_count_q;

endmodule

// ---- bench/ttws_window_status_asserts.sv ----
module ttws_window_status_asserts (
  input wire i_clk,
  input wire i_reset,
  input wire i_field_start,
  input wire i_field_rate_select,
  input wire i_text_insert_enable,
  input wire o_sda_out,
  input wire o_text_request_out,
  input wire o_active_line,
  input wire [1:0] o_text_mode,
  input wire o_field_even,
  input wire [2:0] o_field_seq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ----------------------------------------
  // Field counter and output checks
  // ----------------------------------------
  sequence s_tick;
    i_field_start;
  endsequence
  sequence s_cleared;
    o_field_seq == 3'h0 && !o_text_request_out && !o_active_line;
  endsequence
  property p_step;
    s_tick |=> o_field_seq == ($past(i_field_rate_select)
      ? {1'b0, $past(o_field_seq[1:0]) + 2'h1} : $past(o_field_seq) + 3'h1);
  endproperty
  property p_hold;
    !i_field_start |=> $stable(o_field_seq);
  endproperty
  property p_even;
    o_field_even == o_field_seq[0];
  endproperty
  property p_off;
    !i_text_insert_enable |=> !o_text_request_out;
  endproperty
  property p_wst;
    !i_field_rate_select |=> o_text_mode != 2'h2;
  endproperty
  property p_mode;
    o_text_mode != 2'h3;
  endproperty
  property p_sda;
    o_sda_out == 1'b0;
  endproperty
  property p_rst;
    disable iff (1'b0) i_reset |=> s_cleared;
  endproperty
  a_step: assert property (p_step) else $error("field count step wrong");
  a_hold: assert property (p_hold) else $error("field count moved");
  a_even: assert property (p_even) else $error("odd even bit wrong");
  a_off: assert property (p_off) else $error("text window open while disabled");
  a_wst: assert property (p_wst) else $error("world text at 50 Hz");
  a_mode: assert property (p_mode) else $error("illegal text mode");
  a_sda: assert property (p_sda) else $error("data line driven high");
  a_rst: assert property (p_rst) else $error("outputs not cleared");
endmodule

bind ttws_window_status ttws_window_status_asserts u_chk (.i_clk, .i_reset, .i_field_start,
  .i_field_rate_select, .i_text_insert_enable, .o_sda_out, .o_text_request_out,
  .o_active_line, .o_text_mode, .o_field_even, .o_field_seq);

// ---- bench/ttws_host_model.sv ----
module ttws_host_model (
  input wire i_clk,
  input wire i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  // Bus idles released, clock high
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  task automatic tk(int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic bit_out(logic b);
    tk(1);
    o_sda_low <= !b;
    tk(3);
    o_scl <= 1'b1;
    tk(4);
    o_scl <= 1'b0;
  endtask
  task automatic bit_in(output logic b);
    tk(1);
    o_sda_low <= 1'b0;
    tk(3);
    o_scl <= 1'b1;
    tk(2);
    b = i_sda;
    tk(2);
    o_scl <= 1'b0;
  endtask
  task automatic byte_out(logic [7:0] v, output logic nak);
    for (int i = 7; i >= 0; i--) bit_out(v[i]);
    bit_in(nak);
  endtask
  task automatic start();
    tk(1);
    o_sda_low <= 1'b1;
    tk(4);
    o_scl <= 1'b0;
  endtask
  task automatic stop();
    tk(1);
    o_sda_low <= 1'b1;
    tk(3);
    o_scl <= 1'b1;
    tk(4);
    o_sda_low <= 1'b0;
    tk(4);
  endtask
  // Write: address, subaddress, then data bytes
  task automatic wr(logic [7:0] a, logic [7:0] s, logic [7:0] d[$], output logic nak);
    logic k;
    start();
    byte_out(a, nak);
    if (!nak) begin
      byte_out(s, k);
      foreach (d[i]) byte_out(d[i], k);
    end
    stop();
  endtask
  // Read: status byte straight after the address, closed by a nack
  task automatic rd(logic [7:0] a, output logic [7:0] v, output logic nak);
    v = 8'h00;
    start();
    byte_out(a, nak);
    if (!nak) for (int i = 7; i >= 0; i--) bit_in(v[i]);
    if (!nak) bit_out(1'b1);
    stop();
  endtask
endmodule

// ---- bench/ttws_window_status_bench.sv ----
`include "ttws_defs.vh"
module ttws_window_status_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0, i_reset = 1'b1, fs = 1'b0, fsel = 1'b0, en = 1'b0, cop = 1'b0, cep = 1'b0;
  logic [9:0] line = 10'h000;
  logic [8:0] of = 9'h000, ol = 9'h000;
  logic [7:0] st;
  logic nak;
  wire scl, sda_low, sda_out, sda_oe, req, act, even;
  wire [1:0] mode;
  wire [2:0] seq;
  wire sda = (sda_low | sda_oe) ? 1'b0 : 1'b1;
  int mismatches = 0, check_count = 0, fq = 0, pend[8], cur[8];
  bit cco, cce, w[4];
  always #10 i_clk = ~i_clk;
  ttws_window_status DUT (.i_clk(i_clk), .i_reset(i_reset), .i_scl(scl), .i_sda_in(sda),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_field_start(fs), .i_line_num(line),
    .i_field_rate_select(fsel), .i_text_insert_enable(en), .i_odd_text_first_line(of),
    .i_odd_text_last_line(ol), .i_caption_odd_done(cop), .i_caption_even_done(cep),
    .o_text_request_out(req), .o_active_line(act), .o_text_mode(mode),
    .o_field_even(even), .o_field_seq(seq));
  ttws_host_model host (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
  // ----------------------------------------
  // Compare and model helpers
  // ----------------------------------------
  task automatic chk(string n, logic [9:0] e, logic [9:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_line(string n, int l, logic e, logic g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s line %0d expected %b seen %b", n, l, e, g);
    end
  endtask
  function automatic bit in_win(int l, int a, int b, int hb, int ia, int ib);
    return l >= a + ((hb >> ia) & 1) * 256 + (fsel ? 4 : 1)
      && l <= b + ((hb >> ib) & 1) * 256 + (fsel ? 3 : 0);
  endfunction
  function automatic bit exp_req(int l);
    int k = l - 5;
    bit r = (fq & 1) ? in_win(l, cur[0], cur[1], cur[4], 0, 1) : in_win(l, of, ol, 0, 0, 0);
    if (k >= 0 && k < 16 && (((cur[6] | cur[7] << 8) >> k) & 1)) r = 0;
    return r && en;
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic do_reset();
    if (!i_reset) @(posedge i_clk);
    i_reset <= 1'b1;
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    fq = 0;
    cco = 0;
    cce = 0;
    w = '{0, 0, 0, 0};
    pend = '{default: 0};
    cur = pend;
    @(posedge i_clk);
  endtask
  task automatic wr(logic [7:0] s, logic [7:0] d[$]);
    host.wr(8'h88, s, d, nak);
    chk("write ack", 0, nak);
    foreach (d[i]) begin
      if (s + i >= 8'h78 && s + i <= 8'h7f) pend[s + i - 8'h78] = d[i];
      if (s + i >= 8'h67 && s + i <= 8'h6a) w[s + i - 8'h67] = 1;
    end
    if (w[0] && w[1]) {cco, w[0], w[1]} = 3'b000;
    if (w[2] && w[3]) {cce, w[2], w[3]} = 3'b000;
  endtask
  task automatic rd(logic [7:0] a);
    host.rd(a, st, nak);
    chk("status", {`TTWS_VERSION, cco, cce, fq[2:0]}, st);
  endtask
  task automatic field();
    @(posedge i_clk) fs <= 1'b1;
    @(posedge i_clk) fs <= 1'b0;
    cur = pend;
    fq = (fq + 1) % (fsel ? 4 : 8);
    repeat (2) @(negedge i_clk);
    chk("field count", fq, seq);
    chk("odd even", fq & 1, even);
    if (fsel || !cur[4][7]) chk("mode", fsel ? (cur[4][7] ? 2 : 1) : 0, mode);
  endtask
  task automatic sweep(int top);
    for (int l = 0; l <= top; l++) begin
      @(posedge i_clk) line <= l[9:0];
      en <= $urandom % 4 != 0;
      @(posedge i_clk);
      @(negedge i_clk);
      chk_line("request", l, exp_req(l), req);
      chk_line("active", l, in_win(l, cur[2], cur[3], cur[4], 2, 3), act);
    end
  endtask
  task automatic pulse_cc(bit odd);
    @(posedge i_clk) cop <= odd;
    cep <= !odd;
    @(posedge i_clk) cop <= 1'b0;
    cep <= 1'b0;
    if (odd) cco = 1;
    else cce = 1;
  endtask
  // Main sequence: modes, windows, captions and status
  initial begin
    void'($urandom(32'h670d));
    do_reset();
    for (int i = 0; i < 4; i++) begin
      @(posedge i_clk) fsel <= i[0];
      wr(8'h7c, '{i[1] ? 8'h80 : 8'h00});
      field();
    end
    $display("test modes done");
    for (int f = 1; f >= 0; f--) begin
      do_reset();
      fsel <= f[0];
      of <= 9'($urandom % 40);
      ol <= 9'($urandom % 40 + 20);
      field();
      wr(8'h78, '{8'($urandom % 40), 8'($urandom % 40 + 10), 8'($urandom % 30),
        8'($urandom % 200 + 20), 8'($urandom & 8'h8b)});
      wr(8'h7e, '{8'($urandom), 8'($urandom)});
      sweep(300);
      field();
      sweep(300);
      field();
      sweep(300);
    end
    $display("test windows done");
    do_reset();
    rd(8'h89);
    pulse_cc(1);
    pulse_cc(0);
    rd(8'h8d);
    wr(8'h67, '{8'h11, 8'h22});
    rd(8'h89);
    wr(8'h6a, '{8'h33});
    rd(8'h89);
    wr(8'h69, '{8'h44});
    wr(8'h50, '{8'hff});
    rd(8'h8d);
    host.wr(8'h90, 8'h78, '{8'h01}, nak);
    chk("foreign address ack", 1, nak);
    repeat (9) field();
    rd(8'h89);
    $display("test captions done");
    print_verdict();
  end
  // Watchdog against a hung bus
  initial begin
    #1500000;
    mismatches++;
    print_verdict();
  end
endmodule
